// ==== logic/drs_cfg.svh ====
// Constants of the dual-axis rate sensor register bank: offsets, fields, resets.
// Assumes inclusion by bare name from every design file that needs a figure.
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH

// Register offsets (7-bit address space)
`define DRS_ADDR_MAKER      7'h00
`define DRS_ADDR_ELEMENT    7'h01
`define DRS_ADDR_PART       7'h02
`define DRS_ADDR_REV        7'h03
`define DRS_ADDR_SERIAL0    7'h04
`define DRS_ADDR_SERIAL1    7'h05
`define DRS_ADDR_SERIAL2    7'h06
`define DRS_ADDR_SERIAL3    7'h07
`define DRS_ADDR_RATE1_LO   7'h08
`define DRS_ADDR_RATE1_HI   7'h09
`define DRS_ADDR_RATE2_LO   7'h0a
`define DRS_ADDR_RATE2_HI   7'h0b
`define DRS_ADDR_THERM_LO   7'h0c
`define DRS_ADDR_THERM_HI   7'h0d
`define DRS_ADDR_RSVD_A     7'h0e
`define DRS_ADDR_RSVD_B     7'h0f
`define DRS_ADDR_POWER      7'h10
`define DRS_ADDR_FILTER     7'h11
`define DRS_ADDR_READY      7'h12

// Reset and fixed read values
`define DRS_RST_POWER       2'h0
`define DRS_RST_HPF         4'h0
`define DRS_RST_LPF         3'h0
`define DRS_RST_READY       2'h0
`define DRS_RSVD_A_VAL      8'h00
`define DRS_RSVD_B_VAL      8'h03
`define DRS_ZERO_BYTE       8'h00
`define DRS_ZERO_NIBBLE     4'h0

// Arbitrary identity defaults, not those of any real part
`define DRS_DEF_MAKER       8'h5a
`define DRS_DEF_ELEMENT     8'h3c
`define DRS_DEF_PART        8'h61
`define DRS_DEF_REV         8'h01
`define DRS_DEF_SERIAL      32'h1234_5678

// Field positions
`define DRS_PWR_THERM_BIT   0
`define DRS_PWR_MEAS_BIT    1
`define DRS_FLT_HPF_MSB     7
`define DRS_FLT_HPF_LSB     4
`define DRS_FLT_LPF_MSB     2
`define DRS_FLT_LPF_LSB     0
`define DRS_RDY_MSB         1
`define DRS_RDY_LSB         0
`define DRS_RDY_MODE_DRDY   2'h1

// Serial framing
`define DRS_BIT_LAST        3'h7
`define DRS_BIT_ONE         3'h1
`define DRS_BIT_ZERO        3'h0
`define DRS_ADDR_ONE        7'h01

// Pin synchroniser idle levels {sclk, cs_n, sdi, ready pin}
`define DRS_PIN_IDLE        4'hc
`define DRS_RST_SYNC_IDLE   2'h0

`endif

// ==== logic/drs_pkg.sv ====
// Types shared by the rate sensor register bank and its two helpers.
// Assumes drs_cfg.svh is on the include path.
package drs_pkg;

  // One coherent sample set: both axes and temperature
  typedef struct packed {
    logic [15:0] rate1;
    logic [15:0] rate2;
    logic [11:0] therm;
  } drs_sample_t;

  // Register access requests decoded from the serial frame
  typedef struct packed {
    logic       rd;
    logic       rd_burst;
    logic [6:0] rd_addr;
    logic       wr;
    logic       wr_burst;
    logic [6:0] wr_addr;
    logic [7:0] wdata;
  } drs_req_t;

  // Serial frame phase
  typedef enum logic {
    DRS_HDR,
    DRS_DATA
  } drs_phase_t;

endpackage

// ==== logic/drs_spi_shift.sv ====
// Serial shift engine: clock mode 3, header byte then data bytes, auto-increment.
// Assumes sclk, cs_act and sdi are already synchronised to clk.
`timescale 1ns/1ps
`include "drs_cfg.svh"

module drs_spi_shift (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Synchronised serial pins
  input  wire logic             sclk,
  input  wire logic             cs_act,
  input  wire logic             sdi,
  // Register side
  input  wire logic [7:0]       rd_data,
  output drs_pkg::drs_req_t     req,
  output logic                  sdo
);
  import drs_pkg::*;

  logic        sclk_q_ff, nxt_sclk_q;
  logic [2:0]  cnt_ff, nxt_cnt;
  drs_phase_t  phase_ff, nxt_phase;
  logic [7:0]  shin_ff, nxt_shin;
  logic [7:0]  tx_ff, nxt_tx;
  logic [6:0]  addr_ff, nxt_addr;
  logic        rw_ff, nxt_rw;
  logic        first_ff, nxt_first;
  logic        sdo_ff, nxt_sdo;
  logic        rise;
  logic        fall;
  logic [7:0]  byte_in;

  assign rise    = sclk & ~sclk_q_ff & cs_act;
  assign fall    = ~sclk & sclk_q_ff & cs_act;
  assign byte_in = {shin_ff[6:0], sdi};
  assign sdo     = sdo_ff;

  // Frame sequencing: rw flag, 7-bit address, then data bytes
  always_comb begin
    nxt_sclk_q = sclk;
    nxt_cnt    = cnt_ff;
    nxt_phase  = phase_ff;
    nxt_shin   = shin_ff;
    nxt_tx     = tx_ff;
    nxt_addr   = addr_ff;
    nxt_rw     = rw_ff;
    nxt_first  = first_ff;
    nxt_sdo    = sdo_ff;
    req        = '0;
    if (!cs_act) begin
      nxt_cnt   = `DRS_BIT_ZERO;
      nxt_phase = DRS_HDR;
      nxt_first = 1'b1;
    end else if (rise) begin
      nxt_shin = byte_in;
      nxt_cnt  = cnt_ff + `DRS_BIT_ONE;
      if (cnt_ff == `DRS_BIT_LAST) begin
        case (phase_ff)
          DRS_HDR: begin
            nxt_rw      = byte_in[7];
            nxt_addr    = byte_in[6:0];
            nxt_phase   = DRS_DATA;
            req.rd      = byte_in[7];
            req.rd_addr = byte_in[6:0];
            nxt_tx      = byte_in[7] ? rd_data : `DRS_ZERO_BYTE;
          end
          default: begin
            req.wr       = ~rw_ff;
            req.wr_addr  = addr_ff;
            req.wr_burst = ~first_ff;
            req.wdata    = byte_in;
            nxt_addr     = addr_ff + `DRS_ADDR_ONE;
            nxt_first    = 1'b0;
            req.rd       = rw_ff;
            req.rd_burst = 1'b1;
            req.rd_addr  = addr_ff + `DRS_ADDR_ONE;
            nxt_tx       = rw_ff ? rd_data : `DRS_ZERO_BYTE;
          end
        endcase
      end
    end else if (fall && phase_ff == DRS_DATA) begin
      nxt_sdo = tx_ff[7];
      nxt_tx  = {tx_ff[6:0], 1'b0};
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_ff <= 1'b1;
      cnt_ff    <= `DRS_BIT_ZERO;
      phase_ff  <= DRS_HDR;
      shin_ff   <= `DRS_ZERO_BYTE;
      tx_ff     <= `DRS_ZERO_BYTE;
      addr_ff   <= 7'h00;
      rw_ff     <= 1'b0;
      first_ff  <= 1'b1;
      sdo_ff    <= 1'b0;
    end else if (ce) begin
      sclk_q_ff <= nxt_sclk_q;
      cnt_ff    <= nxt_cnt;
      phase_ff  <= nxt_phase;
      shin_ff   <= nxt_shin;
      tx_ff     <= nxt_tx;
      addr_ff   <= nxt_addr;
      rw_ff     <= nxt_rw;
      first_ff  <= nxt_first;
      sdo_ff    <= nxt_sdo;
    end
  end
endmodule // drs_spi_shift

// ==== logic/drs_snap.sv ====
// Sample store: live copy from the datapath and a frame-frozen shadow for reads.
// Assumes load is a one-cycle pulse on clk and hold is high for a whole frame.
`timescale 1ns/1ps
`include "drs_cfg.svh"

module drs_snap (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Control
  input  wire logic              clear,
  input  wire logic              load,
  input  wire logic              therm_en,
  input  wire logic              hold,
  // Data
  input  drs_pkg::drs_sample_t   sample_in,
  output drs_pkg::drs_sample_t   sample_out
);
  import drs_pkg::*;

  drs_sample_t live_ff, nxt_live;
  drs_sample_t shadow_ff, nxt_shadow;

  assign sample_out = shadow_ff;

  // Live store and frame shadow
  always_comb begin
    nxt_live = live_ff;
    if (clear) begin
      nxt_live = '0;
    end else if (load) begin
      nxt_live.rate1 = sample_in.rate1;
      nxt_live.rate2 = sample_in.rate2;
      if (therm_en) begin
        nxt_live.therm = sample_in.therm;
      end
    end
    nxt_shadow = hold ? shadow_ff : nxt_live;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_ff   <= '0;
      shadow_ff <= '0;
    end else if (ce) begin
      live_ff   <= nxt_live;
      shadow_ff <= nxt_shadow;
    end
  end
endmodule // drs_snap

// ==== logic/drs_regbank.sv ====
// Register bank of a dual-axis angular rate sensor behind a 4-wire serial port.
// Assumes the master drives mode-3 frames no faster than about CLK/8 per bit.
`timescale 1ns/1ps
`include "drs_cfg.svh"

module drs_regbank #(
  parameter logic [7:0]  MAKER_CODE   = `DRS_DEF_MAKER,   // Arbitrary value
  parameter logic [7:0]  ELEMENT_CODE = `DRS_DEF_ELEMENT, // Arbitrary value
  parameter logic [7:0]  PART_CODE    = `DRS_DEF_PART,    // Arbitrary value
  parameter logic [7:0]  REVISION     = `DRS_DEF_REV,     // Arbitrary value
  parameter logic [31:0] SERIAL_NUM   = `DRS_DEF_SERIAL   // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  // Serial port pins
  input  wire logic              SCLK,
  input  wire logic              CS_N,
  input  wire logic              SDI,
  output logic                   SDO,
  output logic                   SDO_OE,
  // Shared ready pin
  input  wire logic              READY_PIN_IN,
  output logic                   READY_PIN_OUT,
  output logic                   READY_PIN_OE,
  output logic                   ANALOG_SELECT,
  // Sample datapath
  input  wire logic              SAMPLE_VALID,
  input  drs_pkg::drs_sample_t   SAMPLE,
  // Settings to the datapath
  output logic                   MEASURE_EN,
  output logic                   THERMAL_SENSOR_ENABLE,
  output logic [3:0]             HIGHPASS_POLE_SELECT,
  output logic [2:0]             LOWPASS_POLE_SELECT
);
  import drs_pkg::*;

  // Reset release and pin synchronisers
  logic [1:0]  rst_sync_ff;
  logic        rst_n_sync;
  logic [3:0]  pin_meta_ff;
  logic [3:0]  pin_ff;
  logic        sclk_s;
  logic        cs_act_s;
  logic        sdi_s;
  logic        rdy_pin_s;

  // Control registers
  logic        therm_en_ff, nxt_therm_en;
  logic        meas_ff, nxt_meas;
  logic [3:0]  hpf_ff, nxt_hpf;
  logic [2:0]  lpf_ff, nxt_lpf;
  logic [1:0]  rdy_cfg_ff, nxt_rdy_cfg;
  logic        drdy_ff, nxt_drdy;
  logic        rdy_out_ff, nxt_rdy_out;
  logic        asel_ff, nxt_asel;
  logic        sclk_q_ff, nxt_sclk_q;
  logic        pend_rd_ff, nxt_pend_rd;

  // Internal nets
  drs_req_t    req;
  drs_sample_t smp;
  logic [7:0]  rd_data;
  logic        sdo_eng;
  logic        wr_ok;
  logic        rd_ok;
  logic        meas_enter;
  logic        sample_take;
  logic        data_read;
  logic        sample_req;
  logic        sclk_fall;

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= `DRS_RST_SYNC_IDLE;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_ff[1];

  // Two-flop synchronisers for SCLK, CS_N, SDI and READY_PIN_IN, one per bit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin_sync
      logic pin_raw;
      logic [3:0] pin_idle;
      assign pin_idle = `DRS_PIN_IDLE;
      assign pin_raw  = (gi == 3) ? SCLK : (gi == 2) ? CS_N : (gi == 1) ? SDI : READY_PIN_IN;
      always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          pin_meta_ff[gi] <= pin_idle[gi];
          pin_ff[gi]      <= pin_idle[gi];
        end else if (CE) begin
          pin_meta_ff[gi] <= pin_raw;
          pin_ff[gi]      <= pin_meta_ff[gi];
        end
      end
    end
  endgenerate
  assign sclk_s    = pin_ff[3];
  assign cs_act_s  = ~pin_ff[2];
  assign sdi_s     = pin_ff[1];
  assign rdy_pin_s = pin_ff[0];

  // Serial engine
  drs_spi_shift u_shift (
    .clk     (CLK),
    .rst_n   (rst_n_sync),
    .ce      (CE),
    .sclk    (sclk_s),
    .cs_act  (cs_act_s),
    .sdi     (sdi_s),
    .rd_data (rd_data),
    .req     (req),
    .sdo     (sdo_eng)
  );

  // Bursts are refused while in standby
  assign wr_ok = req.wr & (meas_ff | ~req.wr_burst);
  assign rd_ok = req.rd & (meas_ff | ~req.rd_burst);

  // Sample acceptance and measurement entry
  assign meas_enter  = wr_ok & (req.wr_addr == `DRS_ADDR_POWER)
                     & req.wdata[`DRS_PWR_MEAS_BIT] & ~meas_ff;
  assign sample_take = SAMPLE_VALID & meas_ff;

  // Sample store, frozen while a frame is open
  drs_snap u_snap (
    .clk        (CLK),
    .rst_n      (rst_n_sync),
    .ce         (CE),
    .clear      (meas_enter),
    .load       (sample_take),
    .therm_en   (therm_en_ff),
    .hold       (cs_act_s),
    .sample_in  (SAMPLE),
    .sample_out (smp)
  );

  // Read decode for the address the engine asks for
  always_comb begin
    rd_data = `DRS_ZERO_BYTE;
    if (!rd_ok) begin
      rd_data = `DRS_ZERO_BYTE;
    end else if (req.rd_addr == `DRS_ADDR_MAKER) begin
      rd_data = MAKER_CODE;
    end else if (req.rd_addr == `DRS_ADDR_ELEMENT) begin
      rd_data = ELEMENT_CODE;
    end else if (req.rd_addr == `DRS_ADDR_PART) begin
      rd_data = PART_CODE;
    end else if (req.rd_addr == `DRS_ADDR_REV) begin
      rd_data = REVISION;
    end else if (req.rd_addr == `DRS_ADDR_SERIAL0) begin
      rd_data = SERIAL_NUM[7:0];
    end else if (req.rd_addr == `DRS_ADDR_SERIAL1) begin
      rd_data = SERIAL_NUM[15:8];
    end else if (req.rd_addr == `DRS_ADDR_SERIAL2) begin
      rd_data = SERIAL_NUM[23:16];
    end else if (req.rd_addr == `DRS_ADDR_SERIAL3) begin
      rd_data = SERIAL_NUM[31:24];
    end else if (req.rd_addr == `DRS_ADDR_RATE1_LO) begin
      rd_data = smp.rate1[7:0];
    end else if (req.rd_addr == `DRS_ADDR_RATE1_HI) begin
      rd_data = smp.rate1[15:8];
    end else if (req.rd_addr == `DRS_ADDR_RATE2_LO) begin
      rd_data = smp.rate2[7:0];
    end else if (req.rd_addr == `DRS_ADDR_RATE2_HI) begin
      rd_data = smp.rate2[15:8];
    end else if (req.rd_addr == `DRS_ADDR_THERM_LO) begin
      rd_data = smp.therm[7:0];
    end else if (req.rd_addr == `DRS_ADDR_THERM_HI) begin
      rd_data = {`DRS_ZERO_NIBBLE, smp.therm[11:8]};
    end else if (req.rd_addr == `DRS_ADDR_RSVD_A) begin
      rd_data = `DRS_RSVD_A_VAL;
    end else if (req.rd_addr == `DRS_ADDR_RSVD_B) begin
      rd_data = `DRS_RSVD_B_VAL;
    end else if (req.rd_addr == `DRS_ADDR_POWER) begin
      rd_data = {6'h00, meas_ff, therm_en_ff};
    end else if (req.rd_addr == `DRS_ADDR_FILTER) begin
      rd_data = {hpf_ff, 1'b0, lpf_ff};
    end else if (req.rd_addr == `DRS_ADDR_READY) begin
      rd_data = {6'h00, rdy_cfg_ff};
    end
  end

  // A granted read of any sample byte arms the consume flag
  assign sample_req = rd_ok & (req.rd_addr >= `DRS_ADDR_RATE1_LO)
                    & (req.rd_addr <= `DRS_ADDR_THERM_HI);
  assign sclk_fall  = ~sclk_s & sclk_q_ff & cs_act_s;

  // A byte counts as read only once the master clocks it out;
  // the prefetch at the end of a frame dies with the frame
  always_comb begin
    nxt_sclk_q  = sclk_s;
    nxt_pend_rd = pend_rd_ff;
    data_read   = 1'b0;
    if (!cs_act_s) begin
      nxt_pend_rd = 1'b0;
    end else if (req.rd) begin
      nxt_pend_rd = sample_req;
    end else if (sclk_fall) begin
      data_read   = pend_rd_ff;
      nxt_pend_rd = 1'b0;
    end
  end

  // Consume tracking registers
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sclk_q_ff  <= 1'b1;
      pend_rd_ff <= 1'b0;
    end else if (CE) begin
      sclk_q_ff  <= nxt_sclk_q;
      pend_rd_ff <= nxt_pend_rd;
    end
  end

  // Writable settings; fixed bits and read-only addresses drop writes
  always_comb begin
    nxt_therm_en = therm_en_ff;
    nxt_meas     = meas_ff;
    nxt_hpf      = hpf_ff;
    nxt_lpf      = lpf_ff;
    nxt_rdy_cfg  = rdy_cfg_ff;
    if (wr_ok) begin
      if (req.wr_addr == `DRS_ADDR_POWER) begin
        nxt_therm_en = req.wdata[`DRS_PWR_THERM_BIT];
        nxt_meas     = req.wdata[`DRS_PWR_MEAS_BIT];
      end else if (req.wr_addr == `DRS_ADDR_FILTER) begin
        nxt_hpf = req.wdata[`DRS_FLT_HPF_MSB:`DRS_FLT_HPF_LSB];
        nxt_lpf = req.wdata[`DRS_FLT_LPF_MSB:`DRS_FLT_LPF_LSB];
      end else if (req.wr_addr == `DRS_ADDR_READY) begin
        nxt_rdy_cfg = req.wdata[`DRS_RDY_MSB:`DRS_RDY_LSB];
      end
    end
  end

  // Settings registers
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      therm_en_ff <= `DRS_RST_POWER == 2'h0 ? 1'b0 : 1'b1;
      meas_ff     <= 1'b0;
      hpf_ff      <= `DRS_RST_HPF;
      lpf_ff      <= `DRS_RST_LPF;
      rdy_cfg_ff  <= `DRS_RST_READY;
    end else if (CE) begin
      therm_en_ff <= nxt_therm_en;
      meas_ff     <= nxt_meas;
      hpf_ff      <= nxt_hpf;
      lpf_ff      <= nxt_lpf;
      rdy_cfg_ff  <= nxt_rdy_cfg;
    end
  end

  // Data-ready flag: a new sample wins over a read in the same cycle
  always_comb begin
    nxt_drdy = drdy_ff;
    if (meas_enter) begin
      nxt_drdy = 1'b0;
    end else if (sample_take) begin
      nxt_drdy = 1'b1;
    end else if (data_read) begin
      nxt_drdy = 1'b0;
    end
    nxt_rdy_out = (rdy_cfg_ff == `DRS_RDY_MODE_DRDY) & nxt_drdy;
    nxt_asel    = ~rdy_cfg_ff[0] & rdy_pin_s;
  end

  // Ready pin registers
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      drdy_ff    <= 1'b0;
      rdy_out_ff <= 1'b0;
      asel_ff    <= 1'b0;
    end else if (CE) begin
      drdy_ff    <= nxt_drdy;
      rdy_out_ff <= nxt_rdy_out;
      asel_ff    <= nxt_asel;
    end
  end

  // Pin and datapath outputs
  assign SDO                   = sdo_eng;
  assign SDO_OE                = cs_act_s;
  assign READY_PIN_OUT         = rdy_out_ff;
  assign READY_PIN_OE          = (rdy_cfg_ff == `DRS_RDY_MODE_DRDY);
  assign ANALOG_SELECT         = asel_ff;
  assign MEASURE_EN            = meas_ff;
  assign THERMAL_SENSOR_ENABLE = therm_en_ff;
  assign HIGHPASS_POLE_SELECT  = hpf_ff;
  assign LOWPASS_POLE_SELECT   = lpf_ff;
endmodule // drs_regbank

// ==== verif/drs_regbank_checker.sv ====
// Port-level assertions for the rate sensor register bank.
// Assumes CE drops only between frames and serial bits no faster than CLK/8.
`timescale 1ns/1ps

module drs_regbank_checker (
  // Clock, reset
  input wire logic       CLK,
  input wire logic       RST_N,
  // Serial port
  input wire logic       SCLK,
  input wire logic       CS_N,
  input wire logic       SDO,
  input wire logic       SDO_OE,
  // Ready pin and samples
  input wire logic       READY_PIN_OUT,
  input wire logic       READY_PIN_OE,
  input wire logic       ANALOG_SELECT,
  input wire logic       SAMPLE_VALID,
  // Settings
  input wire logic       MEASURE_EN,
  input wire logic       THERMAL_SENSOR_ENABLE,
  input wire logic [3:0] HIGHPASS_POLE_SELECT,
  input wire logic [2:0] LOWPASS_POLE_SELECT
);
  // One domain for all checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_rst; $rose(RST_N) |-> !MEASURE_EN && !THERMAL_SENSOR_ENABLE && !READY_PIN_OE; endproperty
  a_rst: assert property (p_rst) else $error("settings not zero after reset");
  property p_oe; (CS_N [*3] |-> !SDO_OE) and (!CS_N [*3] |-> SDO_OE); endproperty
  a_oe: assert property (p_oe) else $error("data out enable not tied to frame");
  property p_sdo; SCLK [*6] |=> $stable(SDO); endproperty
  a_sdo: assert property (p_sdo) else $error("data out moved without clock fall");
  property p_pwr; CS_N [*8] |=> $stable({MEASURE_EN, THERMAL_SENSOR_ENABLE}); endproperty
  a_pwr: assert property (p_pwr) else $error("power settings moved outside a frame");
  property p_flt; CS_N [*8] |=> $stable({HIGHPASS_POLE_SELECT, LOWPASS_POLE_SELECT}); endproperty
  a_flt: assert property (p_flt) else $error("filter settings moved outside a frame");
  property p_set; $rose(READY_PIN_OUT) && $past(READY_PIN_OE, 2) |-> $past(SAMPLE_VALID && MEASURE_EN); endproperty
  a_set: assert property (p_set) else $error("ready rose without a taken sample");
  property p_hold; (CS_N && READY_PIN_OUT) [*8] |=> READY_PIN_OUT; endproperty
  a_hold: assert property (p_hold) else $error("ready dropped without a read");
  property p_asel; (READY_PIN_OE [*2] |-> !ANALOG_SELECT) and (!READY_PIN_OE |=> !READY_PIN_OUT); endproperty
  a_asel: assert property (p_asel) else $error("analog select high in ready mode");
endmodule // drs_regbank_checker

// ==== verif/drs_spi_master.sv ====
// Serial master model: mode 3 frames, header then data bytes, 400 ns bit time.
// Assumes a 50 ns clk; tasks are called from the bench just after a clk edge.
`timescale 1ns/1ps

module drs_spi_master (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [8];

  // Idle: clock stopped high, frame closed
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // One bit: drive on fall, hold over rise, sample just before next fall
  task automatic bitx(input logic b, output logic q);
    #1 sclk = 1'b0;
    sdi = b;
    repeat (4) @(posedge clk);
    #1 sclk = 1'b1;
    repeat (4) @(posedge clk);
    #1 q = sdo;
  endtask

  // Whole frame of n data bytes from or into the buffers
  task automatic xfer(input logic rw, input logic [6:0] a, input int n);
    logic [7:0] h;
    logic       q;
    h = {rw, a};
    @(posedge clk);
    #1 cs_n = 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 7; k >= 0; k--) bitx(h[k], q);
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        bitx(wbuf[i][k], q);
        rbuf[i][k] = q;
      end
    end
    repeat (8) @(posedge clk);
    #1 cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale value
    repeat (8) @(posedge clk);
  endtask
endmodule // drs_spi_master

// ==== verif/drs_regbank_bench.sv ====
// Self-checking bench of the rate sensor register bank through its serial port.
// Assumes the serial master model and checker files are compiled before it.
`timescale 1ns/1ps

module drs_regbank_bench;
  import drs_pkg::*;
  `define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end

  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              rpi = 1'b0;
  logic              ce = 1'b1;
  logic              sv = 1'b0;
  logic              sclk, cs_n, sdi, sdo, sdo_oe, rpo, rpoe, asel, meas, tse;
  logic [3:0]        highpass_pole_select;
  logic [2:0]        lowpass_pole_select;
  logic [47:0]       eb;
  wire               pin = rpoe ? rpo : rpi;
  drs_sample_t       smp = '0;
  drs_sample_t       s1, s2;
  int                error_cnt = 0;
  int                checks = 0;
  // Identity values below are arbitrary
  logic [7:0]        ev [19] = '{8'h4b, 8'h2d, 8'h6e, 8'h02, 8'hd4, 8'hc3, 8'hb2, 8'ha1, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};

  always #25 clk = ~clk;

  drs_regbank #(.MAKER_CODE(8'h4b), .ELEMENT_CODE(8'h2d), .PART_CODE(8'h6e), .REVISION(8'h02),
    .SERIAL_NUM(32'ha1b2c3d4)) u_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .SCLK(sclk), .CS_N(cs_n),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .READY_PIN_IN(pin), .READY_PIN_OUT(rpo), .READY_PIN_OE(rpoe),
    .ANALOG_SELECT(asel), .SAMPLE_VALID(sv), .SAMPLE(smp), .MEASURE_EN(meas), .THERMAL_SENSOR_ENABLE(tse),
    .HIGHPASS_POLE_SELECT(highpass_pole_select), .LOWPASS_POLE_SELECT(lowpass_pole_select));
  drs_spi_master u_m (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  // Register access through single-byte frames
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_m.xfer(1'b1, a, 1);
    `CHK("register", e, u_m.rbuf[0])
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_m.wbuf[0] = d;
    u_m.xfer(1'b0, a, 1);
  endtask
  task automatic push(input drs_sample_t s);
    @(posedge clk);
    #1 sv = 1'b1;
    smp = s;
    @(posedge clk);
    #1 sv = 1'b0;
  endtask
  task automatic chk_all();
    for (int a = 0; a < 19; a++) rd(a[6:0], ev[a]);
    rd(7'h13, 8'h00);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    s1 = '{16'h8123, 16'h7ffe, 12'hf9c}; // -100 codes is minus ten degrees
    s2 = '{16'h0102, 16'h0304, 12'h056};
    eb = {4'h0, s1.therm, s1.rate2, s1.rate1};
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1 rpi = 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("analog select", 1'b1, asel)
    `CHK("measure", 1'b0, meas)
    chk_all();
    $display("test reset values done");
    for (int a = 0; a < 16; a++) wr(a[6:0], 8'hff);
    chk_all();
    $display("test read-only done");
    u_m.wbuf[0] = 8'h50;
    u_m.wbuf[1] = 8'h05;
    u_m.xfer(1'b0, 7'h11, 2);
    rd(7'h11, 8'h50);
    rd(7'h12, 8'h00);
    u_m.xfer(1'b1, 7'h0e, 2);
    `CHK("standby burst", 8'h00, u_m.rbuf[1])
    wr(7'h11, 8'hff);
    rd(7'h11, 8'hf7);
    `CHK("highpass", 4'hf, highpass_pole_select)
    `CHK("lowpass", 3'h7, lowpass_pole_select)
    wr(7'h10, 8'hfd);
    rd(7'h10, 8'h01);
    `CHK("thermal enable", 1'b1, tse)
    `CHK("measure", 1'b0, meas)
    wr(7'h10, 8'h03);
    `CHK("measure", 1'b1, meas)
    wr(7'h12, 8'h01);
    `CHK("ready enable", 1'b1, rpoe)
    rd(7'h08, 8'h00);
    $display("test controls done");
    push(s1);
    repeat (3) @(posedge clk);
    #1 `CHK("ready", 1'b1, rpo)
    fork
      u_m.xfer(1'b1, 7'h08, 6);
      begin
        repeat (200) @(posedge clk);
        push(s2);
      end
    join
    for (int i = 0; i < 6; i++) `CHK("burst", eb[8*i +: 8], u_m.rbuf[i])
    `CHK("ready", 1'b0, rpo)
    rd(7'h08, 8'h02);
    wr(7'h10, 8'h00);
    wr(7'h10, 8'h03);
    rd(7'h09, 8'h00);
    $display("test samples done");
    #1 ce = 1'b0;
    push(s1);
    ce = 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK("frozen ready", 1'b0, rpo)
    rd(7'h08, 8'h00);
    wr(7'h10, 8'h02);
    push(s2);
    rd(7'h0c, 8'h00);
    rd(7'h08, 8'h02);
    $display("test enable done");
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule // drs_regbank_bench

bind drs_regbank drs_regbank_checker u_chk (.CLK(CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .SDO(SDO),
  .SDO_OE(SDO_OE), .READY_PIN_OUT(READY_PIN_OUT), .READY_PIN_OE(READY_PIN_OE), .ANALOG_SELECT(ANALOG_SELECT),
  .SAMPLE_VALID(SAMPLE_VALID), .MEASURE_EN(MEASURE_EN), .THERMAL_SENSOR_ENABLE(THERMAL_SENSOR_ENABLE),
  .HIGHPASS_POLE_SELECT(HIGHPASS_POLE_SELECT), .LOWPASS_POLE_SELECT(LOWPASS_POLE_SELECT));
